// ==== imd_cfg.svh ====
// address windows, segment layout and reset values for the isa memory decoder
`ifndef IMD_CFG_SVH
`define IMD_CFG_SVH

// ****************************************************************
// address windows
// ****************************************************************
`define IMD_LOW_BASE 24'h0c0000
`define IMD_LOW_LAST 24'h0dffff
`define IMD_HIGH_BASE 24'hf00000
`define IMD_HIGH_LAST 24'hf1ffff

// ****************************************************************
// segment layout inside a window
// ****************************************************************
`define IMD_SEG_BYTES 18'h20000
`define IMD_BUF_BYTES 18'h14000
`define IMD_REG_FIRST 17'h1ffe0
`define IMD_REG_LAST 17'h1ffff
`define IMD_REG_BYTES 6'h20

// ****************************************************************
// reset values
// ****************************************************************
`define IMD_BIAS_OFF_RST 1'h1
`define IMD_PSAVE_RST 1'h0

`endif

// ==== imd_decoder.sv ====
// isa memory-space decoder placing the lcd controller in a 128k window
//
// Overview of operation
// - with the low window chosen, refresh idle and decode enabled, chip select is asserted for c0000 to dffff.
// - with the high window chosen, refresh idle and decode enabled, chip select is asserted for f00000 to f1ffff.
// - memcs16 is driven low while chip select is active and the address lies in the chosen window.
// - the low-byte write strobe follows smemw in the low window and memw in the high window, only under chip select.
// - the read strobe follows smemr in the low window and memr in the high window, only under chip select.
// - each window is one contiguous 128k segment holding the 80k display buffer and the registers.
// - the register set fills the top 32 bytes of the segment, offsets 1ffe0 to 1ffff.
// - the controller sees buffer and registers alike, so both are plain memory locations.
// - the active-high panel power enable, inverted, switches both panel bias supplies.
// - hardware power save acts only once software enabled it, then follows the switch.
`timescale 1ns/100ps
`include "imd_cfg.svh"

module imd_decoder (
  input wire logic clk,
  input wire logic sys_rst,
  input wire imd_pkg::imd_isa_req_t isa_req,
  input wire logic decode_enable,
  input wire logic map_select_switch,
  input wire logic panel_power_enable,
  input wire logic power_save_sw_enable,
  input wire logic power_save_switch,
  output imd_pkg::imd_ctrl_sel_t ctrl_sel,
  output logic positive_bias_supply_off,
  output logic negative_bias_supply_off,
  output logic power_save_active
);

  // ****************************************************************
  // range decode
  // ****************************************************************
  function automatic logic imd_in_range(
    input logic [23:0] a,
    input logic [23:0] lo,
    input logic [23:0] hi
  );
    imd_in_range = (a >= lo) && (a <= hi);
  endfunction : imd_in_range

  imd_pkg::imd_window_t win;
  logic low_hit;
  logic low_hit_full;
  logic high_hit;
  logic sel_ok;
  logic cs;
  logic win_hit;

  // the low window compares only the 20 system address lines, as an isa
  // card must; memcs16 uses the full 24-bit latched address instead
  always_comb begin
    win = imd_pkg::imd_window_t'(map_select_switch);
    low_hit = imd_in_range({4'h0, isa_req.addr[19:0]}, `IMD_LOW_BASE,
                           `IMD_LOW_LAST);
    low_hit_full = imd_in_range(isa_req.addr, `IMD_LOW_BASE, `IMD_LOW_LAST);
    high_hit = imd_in_range(isa_req.addr, `IMD_HIGH_BASE, `IMD_HIGH_LAST);
    sel_ok = isa_req.refresh_n && decode_enable;
    cs = ((win == imd_pkg::IMD_WIN_LOW) && low_hit && sel_ok) ||
         ((win == imd_pkg::IMD_WIN_HIGH) && high_hit && sel_ok);
    win_hit = (win == imd_pkg::IMD_WIN_LOW) ? low_hit_full : high_hit;
  end

  // ****************************************************************
  // controller select group
  // ****************************************************************
  // no register here: isa strobes and memcs16 must follow the address
  // inside the same bus cycle, so this group departs from the registered
  // output style of the rest of the block
  always_comb begin
    ctrl_sel.chip_select_n = !cs;
    ctrl_sel.memcs16_n = !(cs && win_hit);
    ctrl_sel.low_byte_write_strobe_n = !(cs &&
      ((win == imd_pkg::IMD_WIN_LOW) ? !isa_req.smemw_n
                                     : !isa_req.memw_n));
    ctrl_sel.read_strobe_n = !(cs &&
      ((win == imd_pkg::IMD_WIN_LOW) ? !isa_req.smemr_n
                                     : !isa_req.memr_n));
    // one 128k segment: the low 17 address bits are the offset
    ctrl_sel.offset = isa_req.addr[16:0];
    // informational only; the controller itself does not tell them apart
    ctrl_sel.register_space = cs &&
      (isa_req.addr[16:0] >= `IMD_REG_FIRST);
  end

  // ****************************************************************
  // panel bias and power save
  // ****************************************************************
  logic next_positive_bias_supply_off;
  logic next_negative_bias_supply_off;
  logic next_power_save_active;

  always_comb begin
    next_positive_bias_supply_off = !panel_power_enable;
    next_negative_bias_supply_off = !panel_power_enable;
    next_power_save_active = power_save_sw_enable &&
                             power_save_switch;
  end

  // bias supplies start off so the panel never sees bias before logic
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      positive_bias_supply_off <= `IMD_BIAS_OFF_RST;
      negative_bias_supply_off <= `IMD_BIAS_OFF_RST;
      power_save_active <= `IMD_PSAVE_RST;
    end else begin
      positive_bias_supply_off <= next_positive_bias_supply_off;
      negative_bias_supply_off <= next_negative_bias_supply_off;
      power_save_active <= next_power_save_active;
    end
  end

  // ****************************************************************
  // assertions
  // ****************************************************************
  property p_low_cs;
    @(posedge clk) disable iff (sys_rst)
    (!map_select_switch && decode_enable && isa_req.refresh_n &&
     isa_req.addr[19:0] >= 20'hc0000 && isa_req.addr[19:0] <= 20'hdffff)
    |-> !ctrl_sel.chip_select_n;
  endproperty
  a_low_cs: assert property (p_low_cs)
    else $error("low window chip select missing");

  property p_high_cs;
    @(posedge clk) disable iff (sys_rst)
    !ctrl_sel.chip_select_n && map_select_switch |->
      isa_req.addr >= 24'hf00000 && isa_req.addr <= 24'hf1ffff &&
      decode_enable && isa_req.refresh_n;
  endproperty
  a_high_cs: assert property (p_high_cs)
    else $error("high window chip select out of range");

  property p_memcs16;
    @(posedge clk) disable iff (sys_rst)
    !ctrl_sel.memcs16_n |-> !ctrl_sel.chip_select_n;
  endproperty
  a_memcs16: assert property (p_memcs16)
    else $error("memcs16 without chip select");

  property p_write;
    @(posedge clk) disable iff (sys_rst)
    !ctrl_sel.low_byte_write_strobe_n |-> !ctrl_sel.chip_select_n &&
      (map_select_switch ? !isa_req.memw_n : !isa_req.smemw_n);
  endproperty
  a_write: assert property (p_write)
    else $error("write strobe from wrong source");

  property p_read;
    @(posedge clk) disable iff (sys_rst)
    (!ctrl_sel.chip_select_n && !map_select_switch && !isa_req.smemr_n)
    |-> !ctrl_sel.read_strobe_n;
  endproperty
  a_read: assert property (p_read)
    else $error("read strobe missing in low window");

  property p_segment;
    @(posedge clk) disable iff (sys_rst)
    !ctrl_sel.chip_select_n && map_select_switch |->
      isa_req.addr[23:17] == 7'h78;
  endproperty
  a_segment: assert property (p_segment)
    else $error("chip select outside the 128k segment");

  property p_regspace;
    @(posedge clk) disable iff (sys_rst)
    ctrl_sel.register_space |-> ctrl_sel.offset[16:5] == 12'hfff;
  endproperty
  a_regspace: assert property (p_regspace)
    else $error("register space flag off the top 32 bytes");

  sequence s_panel_on;
    panel_power_enable;
  endsequence

  sequence s_bias_on;
    !positive_bias_supply_off && !negative_bias_supply_off;
  endsequence

  sequence s_bias_off;
    positive_bias_supply_off && negative_bias_supply_off;
  endsequence

  property p_bias;
    @(posedge clk) disable iff (sys_rst)
    s_panel_on |=> s_bias_on;
  endproperty
  a_bias: assert property (p_bias)
    else $error("bias supplies not switched by panel power");

  property p_bias_off;
    @(posedge clk) disable iff (sys_rst)
    !panel_power_enable |=> s_bias_off;
  endproperty
  a_bias_off: assert property (p_bias_off)
    else $error("bias supplies left on without panel power");

  property p_psave;
    @(posedge clk) disable iff (sys_rst)
    !$past(power_save_sw_enable) |-> !power_save_active;
  endproperty
  a_psave: assert property (p_psave)
    else $error("power save without software enable");

  property p_offset;
    @(posedge clk) disable iff (sys_rst)
    !ctrl_sel.chip_select_n |-> ctrl_sel.offset == isa_req.addr[16:0];
  endproperty
  a_offset: assert property (p_offset)
    else $error("offset not following address");

  property p_low_range;
    @(posedge clk) disable iff (sys_rst)
    !ctrl_sel.chip_select_n && !map_select_switch |->
      isa_req.addr[19:0] >= 20'hc0000 && isa_req.addr[19:0] <= 20'hdffff &&
      decode_enable && isa_req.refresh_n;
  endproperty
  a_low_range: assert property (p_low_range)
    else $error("low window chip select out of range");

  property p_high_hit;
    @(posedge clk) disable iff (sys_rst)
    (map_select_switch && decode_enable && isa_req.refresh_n &&
     isa_req.addr >= 24'hf00000 && isa_req.addr <= 24'hf1ffff)
    |-> !ctrl_sel.chip_select_n;
  endproperty
  a_high_hit: assert property (p_high_hit)
    else $error("high window chip select missing");

  property p_memcs16_claim;
    @(posedge clk) disable iff (sys_rst)
    (!ctrl_sel.chip_select_n &&
     (map_select_switch || isa_req.addr[23:20] == 4'h0))
    |-> !ctrl_sel.memcs16_n;
  endproperty
  a_memcs16_claim: assert property (p_memcs16_claim)
    else $error("16-bit claim missing inside the window");

  // an aliased low-window hit must not claim a 16-bit cycle
  property p_memcs16_alias;
    @(posedge clk) disable iff (sys_rst)
    !map_select_switch && isa_req.addr[23:20] != 4'h0 |->
      ctrl_sel.memcs16_n;
  endproperty
  a_memcs16_alias: assert property (p_memcs16_alias)
    else $error("16-bit claim on an address above the low window");

  property p_write_low;
    @(posedge clk) disable iff (sys_rst)
    !ctrl_sel.chip_select_n && !map_select_switch && !isa_req.smemw_n
    |-> !ctrl_sel.low_byte_write_strobe_n;
  endproperty
  a_write_low: assert property (p_write_low)
    else $error("write strobe missing in low window");

  property p_read_src;
    @(posedge clk) disable iff (sys_rst)
    !ctrl_sel.read_strobe_n |-> !ctrl_sel.chip_select_n &&
      (map_select_switch ? !isa_req.memr_n : !isa_req.smemr_n);
  endproperty
  a_read_src: assert property (p_read_src)
    else $error("read strobe from wrong source");

  sequence s_all_idle;
    ctrl_sel.chip_select_n && ctrl_sel.memcs16_n &&
    ctrl_sel.low_byte_write_strobe_n && ctrl_sel.read_strobe_n;
  endsequence

  property p_refresh_idle;
    @(posedge clk) disable iff (sys_rst)
    !isa_req.refresh_n |-> s_all_idle;
  endproperty
  a_refresh_idle: assert property (p_refresh_idle)
    else $error("decode active during refresh");

  property p_disabled_idle;
    @(posedge clk) disable iff (sys_rst)
    !decode_enable |-> s_all_idle;
  endproperty
  a_disabled_idle: assert property (p_disabled_idle)
    else $error("decode active while disabled");

  property p_low_segment;
    @(posedge clk) disable iff (sys_rst)
    !ctrl_sel.chip_select_n && !map_select_switch |->
      isa_req.addr[19:17] == 3'h6;
  endproperty
  a_low_segment: assert property (p_low_segment)
    else $error("chip select outside the low 128k segment");

  property p_reg_hit;
    @(posedge clk) disable iff (sys_rst)
    !ctrl_sel.chip_select_n && ctrl_sel.offset[16:5] == 12'hfff |->
      ctrl_sel.register_space;
  endproperty
  a_reg_hit: assert property (p_reg_hit)
    else $error("register space flag missing in the top 32 bytes");

  // steady inputs must give steady outputs: nothing is remembered
  property p_stateless;
    @(posedge clk) disable iff (sys_rst)
    (isa_req == $past(isa_req) && decode_enable == $past(decode_enable) &&
     map_select_switch == $past(map_select_switch))
    |-> ctrl_sel == $past(ctrl_sel);
  endproperty
  a_stateless: assert property (p_stateless)
    else $error("decode outputs changed with steady inputs");

  property p_psave_on;
    @(posedge clk) disable iff (sys_rst)
    power_save_sw_enable && power_save_switch |=> power_save_active;
  endproperty
  a_psave_on: assert property (p_psave_on)
    else $error("power save not entered on the switch");

  property p_psave_switch;
    @(posedge clk) disable iff (sys_rst)
    !power_save_switch |=> !power_save_active;
  endproperty
  a_psave_switch: assert property (p_psave_switch)
    else $error("power save active with the switch released");

endmodule : imd_decoder

// ==== imd_isa_host.sv ====
// isa bus host model that issues memory cycles toward the decoder
`timescale 1ns/100ps
module imd_isa_host (
  input wire logic [23:0] cyc_addr,
  input wire logic [1:0] cyc_kind,
  input wire logic cyc_on,
  input wire logic refresh_on,
  output imd_pkg::imd_isa_req_t isa_req
);
  // only the isa variant is spoken: straps and bus-start are tied on the
  // board for it and never driven from here
  // a non-isa host would bypass this decoder, so only isa cycles appear
  // one lone strobe per cycle (0 smemr, 1 smemw, 2 memr, 3 memw), so the
  // bench can tell which strobe the decoder really follows in each window
  always_comb begin
    // idle address shows the inverse, never a stale match
    isa_req.addr = cyc_on ? cyc_addr : ~cyc_addr;
    isa_req.refresh_n = ~refresh_on;
    isa_req.smemr_n = ~(cyc_on && cyc_kind == 2'h0);
    isa_req.smemw_n = ~(cyc_on && cyc_kind == 2'h1);
    isa_req.memr_n = ~(cyc_on && cyc_kind == 2'h2);
    isa_req.memw_n = ~(cyc_on && cyc_kind == 2'h3);
  end
endmodule : imd_isa_host

// ==== imd_pkg.sv ====
// types shared by the isa memory decoder
package imd_pkg;

  // ****************************************************************
  // isa side memory request
  // ****************************************************************
  typedef struct packed {
    logic [23:0] addr;
    logic refresh_n;
    logic smemw_n;
    logic memw_n;
    logic smemr_n;
    logic memr_n;
  } imd_isa_req_t;

  // ****************************************************************
  // controller side select group
  // ****************************************************************
  typedef struct packed {
    logic chip_select_n;
    logic memcs16_n;
    logic low_byte_write_strobe_n;
    logic read_strobe_n;
    logic register_space;
    logic [16:0] offset;
  } imd_ctrl_sel_t;

  typedef enum logic [0:0] {
    IMD_WIN_LOW = 1'b0,
    IMD_WIN_HIGH = 1'b1
  } imd_window_t;

endpackage : imd_pkg

// ==== testbench.sv ====
// self-checking bench for the isa memory decoder
`timescale 1ns/100ps
`include "imd_cfg.svh"
module testbench;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic decode_enable = 1'b0;
  logic map_select_switch = 1'b0;
  logic panel_power_enable = 1'b1;
  logic power_save_sw_enable = 1'b1;
  logic power_save_switch = 1'b1;
  logic [23:0] cyc_addr = 24'h000000;
  logic [1:0] cyc_kind = 2'h0;
  logic cyc_on = 1'b0;
  logic refresh_on = 1'b0;
  imd_pkg::imd_isa_req_t isa_req;
  imd_pkg::imd_ctrl_sel_t ctrl_sel;
  logic pos_off;
  logic neg_off;
  logic psave;
  int mismatches = 0;
  int tests_run = 0;
  logic [21:0] exp_v;
  // window edges, register boundary, near misses and a low-window alias
  logic [23:0] adr [10] = '{24'h0bffff, 24'h0c0000, 24'h0dffdf, 24'h0dffe0,
    24'h0dffff, 24'h0e0000, 24'hf00000, 24'hf1ffff, 24'hf20000, 24'h1c0100};

  // bias and power-save flops only; the core input clock stays with the host
  always #12.5 clk = ~clk;

  imd_isa_host host_u (
    .cyc_addr(cyc_addr),
    .cyc_kind(cyc_kind),
    .cyc_on(cyc_on),
    .refresh_on(refresh_on),
    .isa_req(isa_req)
  );

  imd_decoder dut_u (
    .clk(clk),
    .sys_rst(sys_rst),
    .isa_req(isa_req),
    .decode_enable(decode_enable),
    .map_select_switch(map_select_switch),
    .panel_power_enable(panel_power_enable),
    .power_save_sw_enable(power_save_sw_enable),
    .power_save_switch(power_save_switch),
    .ctrl_sel(ctrl_sel),
    .positive_bias_supply_off(pos_off),
    .negative_bias_supply_off(neg_off),
    .power_save_active(psave)
  );

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  function automatic logic [21:0] exp_sel(input logic [23:0] a,
      input logic m, input logic en, input logic rf, input logic [1:0] k);
    logic cs;
    logic c16;
    logic we;
    logic rd;
    // the low window sees the 20 system lines only, so it aliases upward
    cs = en && !rf && (m ? (a >= `IMD_HIGH_BASE && a <= `IMD_HIGH_LAST)
                         : ({4'h0, a[19:0]} >= `IMD_LOW_BASE &&
                            {4'h0, a[19:0]} <= `IMD_LOW_LAST));
    c16 = cs && (m || a <= `IMD_LOW_LAST);
    we = cs && k == (m ? 2'h3 : 2'h1);
    rd = cs && k == (m ? 2'h2 : 2'h0);
    return {~cs, ~c16, ~we, ~rd, cs && a[16:0] >= `IMD_REG_FIRST, a[16:0]};
  endfunction : exp_sel

  task automatic results;
    $display("mismatches %0d tests_run %0d", mismatches, tests_run);
    if (mismatches == 0 && tests_run > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : results

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    repeat (5) @(posedge clk);
    #1 chk({pos_off, neg_off, psave}, 3'b110);
    @(negedge clk) sys_rst = 1'b0;
    @(posedge clk) #1 chk({pos_off, neg_off, psave}, 3'b001);
    @(negedge clk) panel_power_enable = 1'b0;
    power_save_sw_enable = 1'b0;
    @(posedge clk) #1 chk({pos_off, neg_off, psave}, 3'b110);
    @(negedge clk) power_save_sw_enable = 1'b1;
    power_save_switch = 1'b0;
    @(posedge clk) #1 chk({pos_off, neg_off, psave}, 3'b110);
    for (int m = 0; m < 2; m++) begin
      for (int c = 0; c < 3; c++) begin
        for (int i = 0; i < 10; i++) begin
          for (int k = 0; k < 4; k++) begin
            @(negedge clk);
            map_select_switch = m[0];
            decode_enable = (c != 1);
            refresh_on = (c == 2);
            cyc_addr = adr[i];
            cyc_kind = k[1:0];
            cyc_on = 1'b1;
            exp_v = exp_sel(adr[i], m[0], c != 1, c == 2, k[1:0]);
            @(posedge clk);
            #1 chk(ctrl_sel, exp_v);
            // offset and register flag share the same compare
            // buffer and registers decode alike
          end
        end
      end
    end
    results();
  end

  // the sweep needs under 300 cycles; 2000 leaves ample margin
  initial begin
    #50000;
    mismatches++;
    results();
  end
endmodule : testbench
